// file: common/cmd_buf_pkg.sv
package cmd_buf_pkg;

	// =========================================================
	// sizes
	localparam int CHAR_W       = 8;
	localparam int BUF_CHARS    = 255;
	localparam int COUNT_W      = 9;

	// =========================================================
	// buffer mode values, as reported by the mode query
	localparam logic MODE_OFF      = 1'b0;
	localparam logic MODE_ON       = 1'b1;
	localparam logic MODE_POWER_ON = MODE_OFF;
	localparam logic MODE_DEFAULT  = MODE_ON;

	// =========================================================
	// one character of a command message
	typedef struct packed {
		logic [CHAR_W-1:0] data;
		logic              eom;
	} cmd_char_s;

	localparam int CHAR_BITS = $bits(cmd_char_s);

	// =========================================================
	// sequencing of the unbuffered mode
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_WAIT = 2'b10
	} seq_state_e;

endpackage

// file: rtl/char_fifo.sv
`timescale 1ns/1ps

module char_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 255
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  empty,
	output logic                  full
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// =========================================================
	// elaboration checks
	if (WIDTH < 1 || DEPTH < 2) begin : g_size_check
		$error("char_fifo: WIDTH must be >= 1 and DEPTH >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] wr_d;
	logic [PTR_W-1:0] rd_q;
	logic [PTR_W-1:0] rd_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             do_push;
	logic             do_pop;

	function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
		if (p == PTR_W'(DEPTH - 1))
			return '0;
		return p + PTR_W'(1);
	endfunction

	// =========================================================
	// pointers and fill count
	always_comb begin
		do_push = push && !full;
		do_pop  = pop && !empty;
		wr_d    = do_push ? next_ptr(wr_q) : wr_q;
		rd_d    = do_pop ? next_ptr(rd_q) : rd_q;
		cnt_d   = cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (do_push)
			mem[wr_q] <= push_data;
	end

	assign head  = mem[rd_q];
	assign empty = (cnt_q == '0);
	assign full  = (cnt_q == CNT_W'(DEPTH));

endmodule

// file: rtl/bus_command_input_buffer.sv
`timescale 1ns/1ps

// How it works
// - in mode 0 a new command is taken from the bus only while the executor is idle and nothing is pending.
// - in mode 1 incoming characters are stored in the buffer instead of stalling the bus during execution.
// - after reset buffering is off, and the switch command without argument turns it on.
// - in mode 0 one command is handled at a time and the bus stays held until that command has executed.
// - in mode 1 the bus is released once a complete message has been received, while execution goes on.
// - the buffer holds at most 255 characters, and a longer series fills it completely.
// - a full buffer stops the bus from transferring while the earliest commands execute.
// - after a full-buffer stall the remaining characters are taken as space frees up.
// - a ready status bit, readable by serial poll, shows when all buffered work has finished.
// - the mode query answers 0 for buffering off and 1 for buffering on.
module bus_command_input_buffer
	import cmd_buf_pkg::*;
#(
	parameter int CAPACITY = BUF_CHARS
) (
	input  wire logic              mclk,
	input  wire logic              rstn,
	// bus side character stream
	input  wire logic              bus_valid,
	input  wire cmd_char_s         bus_char,
	output logic                   bus_ready,
	output logic                   bus_hold,
	// buffer switch command and mode query
	input  wire logic              switch_cmd,
	input  wire logic              switch_has_arg,
	input  wire logic              switch_arg,
	input  wire logic              mode_query,
	output logic                   query_valid,
	output logic                   query_mode,
	// executor side
	output logic                   exec_valid,
	output cmd_char_s              exec_char,
	input  wire logic              exec_ready,
	input  wire logic              exec_busy,
	input  wire logic              exec_done,
	// status register bit
	output logic                   status_ready
);

	// =========================================================
	// elaboration checks
	if (CAPACITY < 2 || CAPACITY > (2 ** COUNT_W) - 1) begin : g_capacity_check
		$error("bus_command_input_buffer: CAPACITY out of range");
	end

	// =========================================================
	// declarations
	logic                 mode_q;
	logic                 mode_d;
	seq_state_e           state_q;
	seq_state_e           state_d;
	logic [COUNT_W-1:0]   count_q;
	logic [COUNT_W-1:0]   count_d;
	logic                 ready_q;
	logic                 ready_d;
	logic                 hold_q;
	logic                 hold_d;
	logic                 in_msg_q;
	logic                 in_msg_d;
	logic                 slot_valid_q;
	logic                 slot_valid_d;
	cmd_char_s            slot_q;
	cmd_char_s            slot_d;
	logic                 qvalid_q;
	logic                 qvalid_d;
	logic                 qmode_q;
	logic                 qmode_d;
	logic                 stat_q;
	logic                 stat_d;
	logic                 accept;
	logic                 taken;
	logic                 slot_load;
	logic                 fifo_empty;
	logic [CHAR_BITS-1:0] fifo_head;

	function automatic logic has_room(input logic [COUNT_W-1:0] c);
		return c < COUNT_W'(CAPACITY);
	endfunction

	// =========================================================
	// storage
	char_fifo #(
		.WIDTH (CHAR_BITS),
		.DEPTH (CAPACITY)
	) u_fifo (
		.mclk      (mclk),
		.rstn      (rstn),
		.push      (accept),
		.push_data (bus_char),
		.pop       (slot_load),
		.head      (fifo_head),
		.empty     (fifo_empty),
		.full      ()
	);

	// =========================================================
	// mode and query
	always_comb begin
		mode_d   = mode_q;
		qvalid_d = 1'b0;
		qmode_d  = qmode_q;
		if (switch_cmd)
			mode_d = switch_has_arg ? switch_arg : MODE_DEFAULT;
		if (mode_query) begin
			qvalid_d = 1'b1;
			qmode_d  = mode_q;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_q   <= MODE_POWER_ON;
			qvalid_q <= 1'b0;
			qmode_q  <= MODE_POWER_ON;
		end else begin
			mode_q   <= mode_d;
			qvalid_q <= qvalid_d;
			qmode_q  <= qmode_d;
		end
	end

	// =========================================================
	// character flow and output slot
	always_comb begin
		accept       = bus_valid && ready_q;
		taken        = slot_valid_q && exec_ready;
		slot_load    = !fifo_empty && (!slot_valid_q || exec_ready);
		slot_valid_d = slot_load || (slot_valid_q && !exec_ready);
		slot_d       = slot_load ? cmd_char_s'(fifo_head) : slot_q;
		count_d      = count_q + COUNT_W'(accept) - COUNT_W'(taken);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			slot_valid_q <= 1'b0;
			slot_q       <= '0;
			count_q      <= '0;
		end else begin
			slot_valid_q <= slot_valid_d;
			slot_q       <= slot_d;
			count_q      <= count_d;
		end
	end

	// =========================================================
	// bus acceptance and hold
	always_comb begin
		state_d  = state_q;
		in_msg_d = in_msg_q;
		if (accept)
			in_msg_d = !bus_char.eom;
		if (mode_d == MODE_ON) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept)
						state_d = bus_char.eom ? ST_WAIT : ST_RECV;
				end
				ST_RECV: begin
					if (accept && bus_char.eom)
						state_d = ST_WAIT;
				end
				ST_WAIT: begin
					if (exec_done)
						state_d = ST_IDLE;
				end
				default: state_d = ST_IDLE;
			endcase
		end
		if (mode_d == MODE_ON) begin
			ready_d = has_room(count_d);
			hold_d  = in_msg_d;
		end else begin
			case (state_d)
				ST_IDLE: ready_d = (count_d == '0) && !exec_busy && !exec_done;
				ST_RECV: ready_d = has_room(count_d);
				default: ready_d = 1'b0;
			endcase
			hold_d = (state_d != ST_IDLE) || in_msg_d;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q  <= ST_IDLE;
			in_msg_q <= 1'b0;
			ready_q  <= 1'b0;
			hold_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			in_msg_q <= in_msg_d;
			ready_q  <= ready_d;
			hold_q   <= hold_d;
		end
	end

	// =========================================================
	// status ready bit
	always_comb begin
		stat_d = (count_d == '0) && !exec_busy && !in_msg_d && (state_d == ST_IDLE);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			stat_q <= 1'b0;
		else
			stat_q <= stat_d;
	end

	assign bus_ready    = ready_q;
	assign bus_hold     = hold_q;
	assign query_valid  = qvalid_q;
	assign query_mode   = qmode_q;
	assign exec_valid   = slot_valid_q;
	assign exec_char    = slot_q;
	assign status_ready = stat_q;

endmodule

// file: tb/cmd_buf_sva.sv
`timescale 1ns/1ps
module cmd_buf_sva
	import cmd_buf_pkg::*;
#(
	parameter int CAPACITY = BUF_CHARS
) (
	input wire logic      mclk,
	input wire logic      rstn,
	input wire logic      bus_valid,
	input wire cmd_char_s bus_char,
	input wire logic      bus_ready,
	input wire logic      bus_hold,
	input wire logic      switch_cmd,
	input wire logic      switch_has_arg,
	input wire logic      switch_arg,
	input wire logic      mode_query,
	input wire logic      query_valid,
	input wire logic      query_mode,
	input wire logic      exec_valid,
	input wire cmd_char_s exec_char,
	input wire logic      exec_ready,
	input wire logic      exec_busy,
	input wire logic      exec_done,
	input wire logic      status_ready
);
	// =====
	// mode and fill level seen from outside
	logic               mode_q, mode_d;
	logic [COUNT_W-1:0] cnt_q, cnt_d;
	always_comb begin
		mode_d = mode_q;
		if (switch_cmd)
			mode_d = switch_has_arg ? switch_arg : MODE_DEFAULT;
		cnt_d = cnt_q + COUNT_W'(bus_valid && bus_ready) - COUNT_W'(exec_valid && exec_ready);
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= MODE_POWER_ON;
			cnt_q <= '0;
		end else begin
			mode_q <= mode_d;
			cnt_q <= cnt_d;
		end
	end
	// =====
	// properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_eom;
		bus_valid && bus_ready && bus_char.eom && !switch_cmd;
	endsequence
	qry_answer_a: assert property (mode_query |=> query_valid && query_mode == $past(mode_q))
		else $error("mode answer wrong");
	qry_pulse_a: assert property (query_valid |-> $past(mode_query))
		else $error("stray answer");
	off_busy_a: assert property (!mode_q && !switch_cmd && !bus_hold && !(bus_valid && bus_ready) && exec_busy |=> !bus_ready)
		else $error("taken while busy");
	off_hold_a: assert property (s_eom ##0 !mode_q |=> bus_hold)
		else $error("bus freed early");
	buf_release_a: assert property (s_eom ##0 mode_q |=> !bus_hold)
		else $error("bus not freed");
	full_stall_a: assert property (cnt_q == CAPACITY |-> !bus_ready)
		else $error("ready when full");
	no_overflow_a: assert property (cnt_q <= CAPACITY)
		else $error("overfilled");
	exec_stand_a: assert property (exec_valid && !exec_ready |=> exec_valid && $stable(exec_char))
		else $error("char dropped");
	stat_idle_a: assert property (status_ready |-> !$past(exec_busy))
		else $error("ready while busy");
endmodule

bind bus_command_input_buffer cmd_buf_sva #(.CAPACITY(CAPACITY)) u_sva (.*);

// file: tb/bus_controller_model.sv
`timescale 1ns/1ps
module bus_controller_model
	import cmd_buf_pkg::*;
(
	input wire logic mclk,
	input wire logic bus_ready,
	output logic     bus_valid,
	output cmd_char_s bus_char
);
	logic to_err;
	initial begin
		bus_valid = 1'b0;
		bus_char = '0;
		to_err = 1'b0;
	end
	// =====
	// one character, held until taken, then the lines go stale
	task automatic send(input logic [7:0] d, input logic e);
		int   n;
		logic hit;
		n = 0;
		hit = 1'b0;
		bus_valid = 1'b1;
		bus_char = '{data: d, eom: e};
		// ready is settled here and is what the coming edge samples
		while (!hit && n < 200) begin
			hit = bus_ready;
			@(posedge mclk);
			#1;
			n++;
		end
		if (!hit)
			to_err = 1'b1;
		bus_valid = 1'b0;
		bus_char = ~bus_char;
		// one idle edge so a following send never re-raises valid in this step
		@(posedge mclk);
		#1;
	endtask
endmodule

// file: tb/bus_command_input_buffer_tb_top.sv
`timescale 1ns/1ps
module bus_command_input_buffer_tb_top;
	import cmd_buf_pkg::*;
	localparam int CAPACITY = 4;
	logic       mclk, rstn, bus_valid, bus_ready, bus_hold, switch_cmd, switch_has_arg, switch_arg;
	logic       mode_query, query_valid, query_mode, exec_valid, exec_ready, exec_busy, exec_done;
	logic       status_ready;
	cmd_char_s  bus_char, exec_char;
	int         miscompares, checks_done;
	logic [8:0] got[$];
	bus_command_input_buffer #(.CAPACITY(CAPACITY)) dut (.*);
	bus_controller_model ctl (.mclk, .bus_ready, .bus_valid, .bus_char);
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (exec_valid && exec_ready) got.push_back(exec_char);
	// =====
	// helpers
	task complete_run;
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [8:0] s, input logic [8:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("Error %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task snd(input logic [7:0] d, input logic e);
		ctl.send(d, e);
		if (ctl.to_err) begin
			miscompares++;
			complete_run();
		end
	endtask
	task query(input logic m);
		mode_query = 1;
		tick(1);
		mode_query = 0;
		chk(query_valid, 1);
		chk(query_mode, m);
		tick(1);
		chk(query_valid, 0);
	endtask
	task sw(input logic h, input logic a, input logic m);
		switch_cmd = 1;
		switch_has_arg = h;
		switch_arg = a;
		tick(1);
		switch_cmd = 0;
		query(m);
	endtask
	// =====
	// scenarios
	task t_power;
		query(MODE_OFF);
		chk(status_ready, 1);
		sw(0, 0, 1);
		sw(1, 0, 0);
		sw(1, 1, 1);
		sw(1, 0, 0);
	endtask
	task t_unbuf;
		exec_busy = 1;
		tick(3);
		chk(bus_ready, 0);
		exec_busy = 0;
		snd(8'h41, 0);
		snd(8'h42, 1);
		exec_busy = 1;
		tick(4);
		chk(bus_hold, 1);
		chk(bus_ready, 0);
		chk(got[0], {8'h41, 1'b0});
		chk(got[1], {8'h42, 1'b1});
		exec_busy = 0;
		exec_done = 1;
		tick(1);
		exec_done = 0;
		tick(3);
		chk(bus_hold, 0);
		chk(bus_ready, 1);
		got.delete();
	endtask
	task t_full;
		sw(1, 1, 1);
		exec_ready = 0;
		exec_busy = 1;
		for (int i = 0; i < CAPACITY; i++) snd(8'h50 + i[7:0], 0);
		tick(2);
		chk(bus_ready, 0);
		chk(bus_hold, 1);
		exec_ready = 1;
		snd(8'h54, 0);
		snd(8'h55, 1);
		tick(1);
		chk(bus_hold, 0);
		tick(6);
		chk(got.size(), 6);
		for (int i = 0; i < 6; i++) chk(got[i], {8'h50 + i[7:0], i == 5});
		chk(exec_valid, 0);
		exec_busy = 0;
		tick(3);
		chk(status_ready, 1);
	endtask
	initial begin
		{mclk, rstn, switch_cmd, switch_has_arg, switch_arg, mode_query} = '0;
		{exec_busy, exec_done} = '0;
		exec_ready = 1;
		miscompares = 0;
		checks_done = 0;
		repeat (16) @(posedge mclk);
		#1 rstn = 1;
		tick(2);
		t_power();
		t_unbuf();
		t_full();
		complete_run();
	end
endmodule
